// ===== src/uht_pkg.sv
package uht_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL_A = 8'h00;
    localparam logic [7:0] ADDR_BASE_A = 8'h01;
    localparam logic [7:0] ADDR_LEN_A = 8'h02;
    localparam logic [7:0] ADDR_CTRL_B = 8'h08;
    localparam logic [7:0] ADDR_BASE_B = 8'h09;
    localparam logic [7:0] ADDR_LEN_B = 8'h0A;
    localparam logic [7:0] ADDR_CTRL2 = 8'h0F;

    // ------------------------------------------------------------
    // Host control field positions
    // ------------------------------------------------------------
    localparam int BIT_PREAMBLE = 7;
    localparam int BIT_TOGGLE = 6;
    localparam int BIT_WAIT_FRAME_START = 5;
    localparam int BIT_ISO = 4;
    localparam int BIT_RSVD = 3;
    localparam int BIT_DIR = 2;
    localparam int BIT_ENABLE = 1;
    localparam int BIT_ARM = 0;

    // ------------------------------------------------------------
    // Reset values and sizes
    // ------------------------------------------------------------
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] BASE_RST = 8'h00;
    localparam logic [7:0] LEN_RST = 8'h00;
    localparam logic [7:0] RDATA_RST = 8'h00;
    localparam int FIFO_WIDTH = 8;
    localparam int FIFO_DEPTH = 16;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] base;
        logic [7:0] len;
    } uht_set_t;

    typedef struct packed {
        logic set_b;
        logic preamble;
        logic data1;
        logic iso;
        logic out_dir;
        logic [7:0] length;
    } uht_xfer_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_RUN,
        ST_DRAIN
    } uht_state_t;

endpackage

// ===== src/uht_fifo.sv
`timescale 1ns/1ps
module uht_fifo
    import uht_pkg::*;
#(
    parameter int WIDTH = FIFO_WIDTH,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_flush,
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready,
    output logic [$clog2(DEPTH):0] o_count
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] count;
        logic [WIDTH-1:0] head;
        logic valid;
        logic full;
    } uht_fifo_state_t;

    uht_fifo_state_t s_ff;
    uht_fifo_state_t nxt_s;
    logic push;
    logic pop;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        push = i_in_valid & ~s_ff.full;
        pop = s_ff.valid & i_out_ready;
        nxt_s = s_ff;
        if (i_flush) begin
            nxt_s.wr = '0;
            nxt_s.rd = '0;
            nxt_s.count = '0;
        end else begin
            if (push) begin
                nxt_s.mem[s_ff.wr] = i_in_data;
                nxt_s.wr = AW'(s_ff.wr + 1'b1);
            end
            if (pop) begin
                nxt_s.rd = AW'(s_ff.rd + 1'b1);
            end
            nxt_s.count = (AW+1)'(s_ff.count + (AW+1)'(push) - (AW+1)'(pop));
        end
        nxt_s.head = nxt_s.mem[nxt_s.rd];
        nxt_s.valid = (nxt_s.count != '0);
        nxt_s.full = (nxt_s.count == (AW+1)'(DEPTH));
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign o_in_ready = ~s_ff.full;
    assign o_out_valid = s_ff.valid;
    assign o_out_data = s_ff.head;
    assign o_count = s_ff.count;

endmodule

// ===== src/uht_transfer.sv
`timescale 1ns/1ps
// Function
// [R1] Preamble bit sends preamble before low-speed packet
// [R2] Software sets preamble only for hub-attached low-speed
// [R3] Via hub: full speed, full polarity, preamble set
// [R4] Direct low-speed mode ignores the preamble bit
// [R5] Toggle selects DATA0/DATA1, OUT transfers only
// [R6] Frame-start wait holds packet until after SOF
// [R7] Frame-start wait is used only at full speed
// [R8] Isochronous bit marks packet as isochronous
// [R9] Control bit three is reserved, no function
// [R10] Direction one is OUT, zero is IN
// [R11] Transfer runs only with enable and arm set
// [R12] Arm clears itself together with completion pulse
// [R13] Software programs set registers, then writes control
// [R14] Two identical control registers, sets A and B
// [R15] Base register points into packet buffer
// [R16] Both base registers may be loaded before arming
// [R17] Double buffering may split DATA0 and DATA1 buffers
// [R18] Set B used only after control 0Fh write
// [R19] Reset clears arm bits of both control registers
// [R20] Sets overlap; finished set hands over to other
// [R21] Buffer address steps by one per data byte
module uht_transfer
    import uht_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    input wire logic i_engine_low_speed,
    input wire logic i_engine_busy,
    input wire logic i_sof_sent,
    input wire logic i_engine_done,
    output logic o_xfer_req,
    output uht_xfer_t o_xfer,
    output logic [7:0] o_tx_data,
    output logic o_tx_valid,
    input wire logic i_tx_ready,
    input wire logic [7:0] i_rx_data,
    input wire logic i_rx_valid,
    output logic o_rx_ready,
    output logic o_buf_re,
    output logic o_buf_we,
    output logic [7:0] o_buf_addr,
    output logic [7:0] o_buf_wdata,
    input wire logic [7:0] i_buf_rdata,
    output logic o_done,
    output logic o_busy
);
    localparam int CW = $clog2(DEPTH) + 1;
    localparam logic [CW-1:0] ROOM_LIMIT = CW'(DEPTH - 3);

    typedef struct packed {
        uht_set_t [1:0] sets;
        logic ext_mode;
        uht_state_t st;
        logic cur_b;
        logic last_b;
        logic [7:0] addr;
        logic [7:0] issued;
        logic rd_pend;
        logic [7:0] rdata;
        logic req;
        uht_xfer_t xfer;
        logic done;
        logic buf_re;
        logic buf_we;
        logic [7:0] buf_addr;
        logic [7:0] buf_wdata;
        logic rx_ready;
        logic flush;
        logic busy;
    } uht_top_state_t;

    uht_top_state_t s_ff;
    uht_top_state_t nxt_s;

    logic fifo_in_valid;
    logic [7:0] fifo_in_data;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic fifo_out_ready;
    logic [CW-1:0] fifo_count;
    logic go_a;
    logic go_b;
    logic [7:0] cur_ctrl;
    logic cur_out;

    // ------------------------------------------------------------
    // Data buffer between packet memory and serial engine
    // ------------------------------------------------------------
    always_comb begin
        cur_ctrl = s_ff.sets[s_ff.cur_b].ctrl;
        cur_out = cur_ctrl[BIT_DIR];                                  // [R10]
        if (cur_out) begin
            fifo_in_valid = s_ff.rd_pend;
            fifo_in_data = i_buf_rdata;
            fifo_out_ready = i_tx_ready;
        end else begin
            fifo_in_valid = i_rx_valid & s_ff.rx_ready;
            fifo_in_data = i_rx_data;
            fifo_out_ready = (s_ff.st == ST_RUN) || (s_ff.st == ST_DRAIN);
        end
    end

    uht_fifo #(
        .WIDTH(8),
        .DEPTH(DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_flush(s_ff.flush),
        .i_in_valid(fifo_in_valid),
        .i_in_data(fifo_in_data),
        .o_in_ready(fifo_in_ready),
        .o_out_valid(fifo_out_valid),
        .o_out_data(fifo_out_data),
        .i_out_ready(fifo_out_ready),
        .o_count(fifo_count)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        nxt_s = s_ff;
        nxt_s.req = 1'b0;
        nxt_s.done = 1'b0;
        nxt_s.buf_re = 1'b0;
        nxt_s.buf_we = 1'b0;
        nxt_s.flush = 1'b0;
        nxt_s.rd_pend = s_ff.buf_re;

        // ------------------------------------------------------------
        // Start condition per set
        // ------------------------------------------------------------
        go_a = s_ff.sets[0].ctrl[BIT_ENABLE] & s_ff.sets[0].ctrl[BIT_ARM];     // [R11]
        go_b = s_ff.ext_mode                                                   // [R18]
            & s_ff.sets[1].ctrl[BIT_ENABLE] & s_ff.sets[1].ctrl[BIT_ARM];      // [R11]

        unique case (s_ff.st)
            ST_IDLE: begin
                if (go_a && go_b) begin
                    nxt_s.cur_b = ~s_ff.last_b;                                // [R20]
                    nxt_s.st = ST_WAIT;
                end else if (go_a || go_b) begin
                    nxt_s.cur_b = go_b;
                    nxt_s.st = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!(s_ff.cur_b ? go_b : go_a)) begin
                    nxt_s.st = ST_IDLE;                                        // [R11]
                end else if (cur_ctrl[BIT_WAIT_FRAME_START] ? i_sof_sent       // [R6]
                                                            : !i_engine_busy) begin
                    nxt_s.req = 1'b1;
                    nxt_s.xfer.set_b = s_ff.cur_b;
                    nxt_s.xfer.preamble = cur_ctrl[BIT_PREAMBLE]               // [R1]
                        & ~i_engine_low_speed;                                 // [R4]
                    nxt_s.xfer.data1 = cur_ctrl[BIT_TOGGLE] & cur_out;         // [R5]
                    nxt_s.xfer.iso = cur_ctrl[BIT_ISO];                        // [R8]
                    nxt_s.xfer.out_dir = cur_out;                              // [R10]
                    nxt_s.xfer.length = s_ff.sets[s_ff.cur_b].len;
                    nxt_s.addr = s_ff.sets[s_ff.cur_b].base;                   // [R15]
                    nxt_s.issued = 8'h00;
                    nxt_s.flush = 1'b1;
                    nxt_s.st = ST_RUN;
                end
            end
            ST_RUN: begin
                if (i_engine_done) begin
                    if (cur_out) begin
                        nxt_s.flush = 1'b1;
                        nxt_s.done = 1'b1;                                     // [R12]
                        nxt_s.sets[s_ff.cur_b].ctrl[BIT_ARM] = 1'b0;           // [R12]
                        nxt_s.last_b = s_ff.cur_b;                             // [R20]
                        nxt_s.st = ST_IDLE;
                    end else begin
                        nxt_s.st = ST_DRAIN;
                    end
                end else if (cur_out && (s_ff.issued != s_ff.xfer.length)
                             && !s_ff.buf_re && !s_ff.rd_pend
                             && (fifo_count <= ROOM_LIMIT)) begin
                    nxt_s.buf_re = 1'b1;
                    nxt_s.buf_addr = s_ff.addr;
                    nxt_s.addr = 8'(s_ff.addr + 8'h01);                        // [R21]
                    nxt_s.issued = 8'(s_ff.issued + 8'h01);
                end
            end
            ST_DRAIN: begin
                if (!fifo_out_valid) begin
                    nxt_s.done = 1'b1;                                         // [R12]
                    nxt_s.sets[s_ff.cur_b].ctrl[BIT_ARM] = 1'b0;               // [R12]
                    nxt_s.last_b = s_ff.cur_b;                                 // [R20]
                    nxt_s.st = ST_IDLE;
                end
            end
        endcase

        // ------------------------------------------------------------
        // Received bytes go to packet memory
        // ------------------------------------------------------------
        if (!cur_out && fifo_out_valid && fifo_out_ready) begin
            nxt_s.buf_we = 1'b1;
            nxt_s.buf_addr = s_ff.addr;
            nxt_s.buf_wdata = fifo_out_data;
            nxt_s.addr = 8'(s_ff.addr + 8'h01);                                // [R21]
        end

        // ------------------------------------------------------------
        // Registered back-pressure toward the serial engine
        // ------------------------------------------------------------
        nxt_s.rx_ready = (nxt_s.st == ST_RUN) && !nxt_s.xfer.out_dir
            && fifo_in_ready && (fifo_count <= ROOM_LIMIT);

        // ------------------------------------------------------------
        // Busy flag
        // ------------------------------------------------------------
        nxt_s.busy = (nxt_s.st != ST_IDLE);

        // ------------------------------------------------------------
        // Register writes, applied last so a set beats the hardware clear
        // ------------------------------------------------------------
        if (i_reg_wr) begin
            unique case (i_reg_addr)
                ADDR_CTRL_A: begin
                    nxt_s.sets[0].ctrl = i_reg_wdata;                          // [R14]
                    nxt_s.sets[0].ctrl[BIT_RSVD] = 1'b0;                       // [R9]
                end
                ADDR_CTRL_B: begin
                    nxt_s.sets[1].ctrl = i_reg_wdata;                          // [R14]
                    nxt_s.sets[1].ctrl[BIT_RSVD] = 1'b0;                       // [R9]
                end
                ADDR_BASE_A: nxt_s.sets[0].base = i_reg_wdata;                 // [R15]
                ADDR_BASE_B: nxt_s.sets[1].base = i_reg_wdata;                 // [R15]
                ADDR_LEN_A: nxt_s.sets[0].len = i_reg_wdata;
                ADDR_LEN_B: nxt_s.sets[1].len = i_reg_wdata;
                ADDR_CTRL2: nxt_s.ext_mode = 1'b1;                             // [R18]
                default: begin
                end
            endcase
        end

        // ------------------------------------------------------------
        // Register reads
        // ------------------------------------------------------------
        if (i_reg_rd) begin
            unique case (i_reg_addr)
                ADDR_CTRL_A: nxt_s.rdata = s_ff.sets[0].ctrl;
                ADDR_CTRL_B: nxt_s.rdata = s_ff.sets[1].ctrl;
                ADDR_BASE_A: nxt_s.rdata = s_ff.sets[0].base;
                ADDR_BASE_B: nxt_s.rdata = s_ff.sets[1].base;
                ADDR_LEN_A: nxt_s.rdata = s_ff.sets[0].len;
                ADDR_LEN_B: nxt_s.rdata = s_ff.sets[1].len;
                default: nxt_s.rdata = RDATA_RST;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            s_ff <= '0;
            s_ff.sets[0].ctrl <= CTRL_RST;                                     // [R19]
            s_ff.sets[1].ctrl <= CTRL_RST;                                     // [R19]
            s_ff.sets[0].base <= BASE_RST;
            s_ff.sets[1].base <= BASE_RST;
            s_ff.sets[0].len <= LEN_RST;
            s_ff.sets[1].len <= LEN_RST;
            s_ff.st <= ST_IDLE;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_reg_rdata = s_ff.rdata;
    assign o_xfer_req = s_ff.req;
    assign o_xfer = s_ff.xfer;
    assign o_tx_data = fifo_out_data;
    assign o_tx_valid = fifo_out_valid;
    assign o_rx_ready = s_ff.rx_ready;
    assign o_buf_re = s_ff.buf_re;
    assign o_buf_we = s_ff.buf_we;
    assign o_buf_addr = s_ff.buf_addr;
    assign o_buf_wdata = s_ff.buf_wdata;
    assign o_done = s_ff.done;
    assign o_busy = s_ff.busy;

endmodule

// ===== sim/uht_transfer_properties.sv
`timescale 1ns/1ps
module uht_transfer_properties
    import uht_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_reg_rd,
    input wire logic [7:0] o_reg_rdata,
    input wire logic i_engine_low_speed,
    input wire logic i_engine_busy,
    input wire logic i_sof_sent,
    input wire logic o_xfer_req,
    input wire uht_xfer_t o_xfer,
    input wire logic o_buf_re,
    input wire logic o_buf_we,
    input wire logic [7:0] o_buf_addr,
    input wire logic o_done,
    input wire logic o_busy
);
    // ----
    // Last buffer address of the running transfer
    // ----
    logic [7:0] last_ff;
    logic seen_ff;
    always_ff @(posedge i_clk) begin
        if (!i_rst_n || o_xfer_req) begin
            seen_ff <= 1'b0;
        end else if (o_buf_re || o_buf_we) begin
            seen_ff <= 1'b1;
            last_ff <= o_buf_addr;
        end
    end
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    a_req_single: assert property (o_xfer_req |=> !o_xfer_req)
        else $error("start pulse longer than one cycle");
    a_done_single: assert property (o_done |=> !o_done)
        else $error("done pulse longer than one cycle");
    a_done_idle: assert property (o_done |-> !o_busy)
        else $error("done while still busy");
    a_req_engine_idle: assert property (
        o_xfer_req && !$past(i_sof_sent) |-> !$past(i_engine_busy))
        else $error("start while engine busy");
    a_xfer_hold: assert property (!o_xfer_req |-> $stable(o_xfer))
        else $error("descriptor changed without start");
    a_preamble_low: assert property (
        o_xfer_req && $past(i_engine_low_speed) |-> !o_xfer.preamble)
        else $error("preamble at direct low speed");
    a_toggle_in: assert property (o_xfer_req && !o_xfer.out_dir |-> !o_xfer.data1)
        else $error("toggle applied to IN");
    a_addr_step: assert property (
        (o_buf_re || o_buf_we) && seen_ff |-> o_buf_addr == last_ff + 8'h01)
        else $error("buffer address did not step by one");
    a_rdata_hold: assert property (!$past(i_reg_rd) |-> $stable(o_reg_rdata))
        else $error("read data changed without read");
    a_buf_busy: assert property (
        (o_buf_re || o_buf_we) |-> o_busy && !(o_buf_re && o_buf_we))
        else $error("buffer access outside transfer");
endmodule

// ===== sim/uht_engine_model.sv
`timescale 1ns/1ps
module uht_engine_model
    import uht_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_xfer_req,
    input wire uht_xfer_t i_xfer,
    input wire logic [7:0] i_tx_data,
    input wire logic i_tx_valid,
    output logic o_tx_ready,
    output logic [7:0] o_rx_data,
    output logic o_rx_valid,
    input wire logic i_rx_ready,
    input wire logic i_buf_re,
    input wire logic i_buf_we,
    input wire logic [7:0] i_buf_addr,
    input wire logic [7:0] i_buf_wdata,
    output logic [7:0] o_buf_rdata,
    output logic o_busy,
    output logic o_done
);
    // ----
    // Packet buffer and serial engine
    // ----
    logic [7:0] mem [256];
    logic [7:0] txq [$];
    bit run;
    int cnt;
    bit fin;
    initial begin
        {o_tx_ready, o_rx_valid, o_busy, o_done} = 4'h0;
        o_rx_data = 8'h00;
        o_buf_rdata = 8'h00;
    end
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            run = 1'b0;
            {o_tx_ready, o_rx_valid, o_busy, o_done} <= #1 4'h0;
        end else begin
            fin = 1'b0;
            o_buf_rdata <= #1 i_buf_re ? mem[i_buf_addr] : ~o_buf_rdata;
            if (i_buf_we) mem[i_buf_addr] = i_buf_wdata;
            if (i_xfer_req) begin
                run = 1'b1;
                cnt = 0;
            end else if (run) begin
                if (i_xfer.out_dir && i_tx_valid && o_tx_ready) begin
                    txq.push_back(i_tx_data);
                    cnt++;
                end
                if (!i_xfer.out_dir && o_rx_valid && i_rx_ready) cnt++;
                if (cnt == int'(i_xfer.length)) begin
                    run = 1'b0;
                    fin = 1'b1;
                end
            end
            o_done <= #1 fin;
            o_busy <= #1 run;
            o_tx_ready <= #1 run & ~o_tx_ready;
            o_rx_valid <= #1 run && !i_xfer_req && !i_xfer.out_dir;
            o_rx_data <= #1 (run && !i_xfer_req) ? 8'hA0 + cnt[7:0] : ~o_rx_data;
        end
    end
endmodule

// ===== sim/test_uht_transfer.sv
`timescale 1ns/1ps
module test_uht_transfer
    import uht_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, ls = 1'b0, sof = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, txd, rxd, baddr, bwd, brd, d;
    logic busy, edone, req, txv, txr, rxv, rxr, bre, bwe, done, obusy;
    uht_xfer_t xfer;
    int num_errors = 0, n_checks = 0;
    always #2.5 clk = ~clk;
    uht_transfer uht_transfer_i (.i_clk(clk), .i_rst_n(rst_n), .i_reg_wr(wr), .i_reg_rd(rd),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .i_engine_low_speed(ls), .i_engine_busy(busy), .i_sof_sent(sof),
        .i_engine_done(edone), .o_xfer_req(req), .o_xfer(xfer), .o_tx_data(txd),
        .o_tx_valid(txv), .i_tx_ready(txr), .i_rx_data(rxd), .i_rx_valid(rxv),
        .o_rx_ready(rxr), .o_buf_re(bre), .o_buf_we(bwe), .o_buf_addr(baddr),
        .o_buf_wdata(bwd), .i_buf_rdata(brd), .o_done(done), .o_busy(obusy));
    uht_engine_model uht_engine_model_i (.i_clk(clk), .i_rst_n(rst_n), .i_xfer_req(req),
        .i_xfer(xfer), .i_tx_data(txd), .i_tx_valid(txv), .o_tx_ready(txr),
        .o_rx_data(rxd), .o_rx_valid(rxv), .i_rx_ready(rxr), .i_buf_re(bre),
        .i_buf_we(bwe), .i_buf_addr(baddr), .i_buf_wdata(bwd), .o_buf_rdata(brd),
        .o_busy(busy), .o_done(edone));
    // ----
    // Tasks
    // ----
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic check(input logic [12:0] seen, input logic [12:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        #1 wr = 1'b1;
        addr = a;
        wdata = v;
        @(posedge clk);
        #1 wr = 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        #1 rd = 1'b1;
        addr = a;
        @(posedge clk);
        #1 rd = 1'b0;
        v = rdata;
    endtask
    task automatic wait_on(input bit want_done, input int n);
        int k;
        k = 0;
        while ((want_done ? done : req) !== 1'b1 && k < n) begin
            @(posedge clk);
            #1 k++;
        end
        if ((want_done ? done : req) !== 1'b1) begin
            num_errors++;
            $display("ERROR %0t: wait ran out", $time);
            tally_and_finish();
        end
    endtask
    task automatic quiet(input int n);
        repeat (n) begin
            @(posedge clk);
            #1 check(req, 1'b0);
        end
    endtask
    // ----
    // Main sequence
    // ----
    initial begin
        repeat (5) @(posedge clk);
        #1 rst_n = 1'b1;
        reg_rd(ADDR_CTRL_A, d);
        check(d, CTRL_RST);
        reg_rd(ADDR_CTRL_B, d);
        check(d, CTRL_RST);
        reg_rd(8'h05, d);
        check(d, RDATA_RST);
        reg_wr(ADDR_BASE_A, 8'h20);
        reg_wr(ADDR_LEN_A, 8'h03);
        reg_wr(ADDR_BASE_B, 8'h40);
        reg_wr(ADDR_LEN_B, 8'h02);
        reg_wr(ADDR_CTRL_A, 8'hF8);
        reg_rd(ADDR_CTRL_A, d);
        check(d, 8'hF0);
        reg_wr(ADDR_CTRL_B, 8'hC3);
        quiet(10);
        check(obusy, 1'b0);
        for (int i = 0; i < 3; i++) uht_engine_model_i.mem[8'h20 + i] = 8'h51 + 8'h11 * i;
        for (int r = 0; r < 2; r++) begin
            uht_engine_model_i.txq.delete();
            reg_wr(ADDR_CTRL_A, r ? 8'h37 : 8'h47);
            if (r) begin
                quiet(20);
                check(obusy, 1'b1);
                @(posedge clk);
                #1 sof = 1'b1;
                @(posedge clk);
                #1 sof = 1'b0;
            end
            wait_on(1'b0, 6);
            check(xfer, {1'b0, 1'b0, r == 0, r == 1, 1'b1, 8'h03});
            wait_on(1'b1, 200);
            check(obusy, 1'b0);
            check(uht_engine_model_i.txq.size(), 3);
            for (int i = 0; i < 3; i++) check(uht_engine_model_i.txq[i], 8'h51 + 8'h11 * i);
            reg_rd(ADDR_CTRL_A, d);
            check(d, r ? 8'h36 : 8'h46);
        end
        reg_rd(ADDR_BASE_A, d);
        check(d, 8'h20);
        for (int s = 0; s < 2; s++) begin
            ls = s[0];
            uht_engine_model_i.mem[8'h40] = 8'h00;
            uht_engine_model_i.mem[8'h41] = 8'h00;
            if (s) reg_wr(ADDR_CTRL_B, 8'hC3);
            else reg_wr(ADDR_CTRL2, 8'h00);
            wait_on(1'b0, 10);
            check(xfer, {1'b1, s == 0, 1'b0, 1'b0, 1'b0, 8'h02});
            wait_on(1'b1, 200);
            check(obusy, 1'b0);
            check(uht_engine_model_i.mem[8'h40], 8'hA0);
            check(uht_engine_model_i.mem[8'h41], 8'hA1);
            reg_rd(ADDR_CTRL_B, d);
            check(d, 8'hC2);
        end
        tally_and_finish();
    end
endmodule
bind uht_transfer uht_transfer_properties uht_transfer_properties_i (.i_clk, .i_rst_n,
    .i_reg_rd, .o_reg_rdata, .i_engine_low_speed, .i_engine_busy, .i_sof_sent,
    .o_xfer_req, .o_xfer,
    .o_buf_re, .o_buf_we, .o_buf_addr, .o_done, .o_busy);
